// ### host_slave_port.sv
// Host slave register port, interrupt output and SCSI clock gate
//
// Overview of operation
// - Cycle selected when chip select sampled after strobe
// - Next-address input ignored in slave cycles
// - Status register read releases interrupt output
// - Release timed from ready-in completing edge
// - Interrupt held low at least three clocks
// - At least six clocks released before reasserting interrupt
// - Write data six, read data two clocks early
// - SCSI clock enabled by test register bit seven
`default_nettype none
module host_slave_port (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic address_strobe_n_i,
    input wire logic host_chip_select_n_i,
    input wire logic next_address_n_i,
    input wire logic write_n_i,
    input wire logic [host_port_pkg::ADDR_W-1:0] addr_i,
    input wire logic [host_port_pkg::DATA_W-1:0] wdata_i,
    input wire logic ready_in_n_i,
    input wire logic [7:0] dma_status_i,
    input wire logic [7:0] scsi_status_first_i,
    input wire logic irq_event_i,
    output logic [host_port_pkg::DATA_W-1:0] rdata_o,
    output logic rdata_oe_n_o,
    output logic ready_out_n_o,
    output logic irq_n_o,
    output logic scsi_clk_en_o,
    output logic [7:0] chip_test_eighth_o
);
    // ======================================================================
    // Input synchronisers
    logic [2:0] ads_sync_q;
    logic [2:0] hcs_sync_q;
    logic [2:0] rdy_sync_q;
    logic ads_n_q;
    logic hcs_n_q;
    logic rdy_n_q;

    // Three-stage capture; a change counts once stages two and three agree
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ads_sync_q <= 3'h7;
            hcs_sync_q <= 3'h7;
            rdy_sync_q <= 3'h7;
            ads_n_q <= 1'b1;
            hcs_n_q <= 1'b1;
            rdy_n_q <= 1'b1;
        end
        else
        begin
            ads_sync_q <= {ads_sync_q[1:0], address_strobe_n_i};
            hcs_sync_q <= {hcs_sync_q[1:0], host_chip_select_n_i};
            rdy_sync_q <= {rdy_sync_q[1:0], ready_in_n_i};
            if (ads_sync_q[1] == ads_sync_q[2])
                ads_n_q <= ads_sync_q[2];
            if (hcs_sync_q[1] == hcs_sync_q[2])
                hcs_n_q <= hcs_sync_q[2];
            if (rdy_sync_q[1] == rdy_sync_q[2])
                rdy_n_q <= rdy_sync_q[2];
        end
    end

    // ======================================================================
    // Slave cycle sequencer
    host_port_pkg::slave_state_t state_q;
    logic ads_seen_q;
    logic is_write_q;
    logic [host_port_pkg::ADDR_W-1:0] addr_q;
    logic [host_port_pkg::CNT_W-1:0] setup_cnt_q;
    logic cycle_done;
    logic status_read_done;

    // Strobe pulse is latched; its rising end marks the select sample point
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ads_seen_q <= 1'b0;
        else if (state_q != host_port_pkg::ST_IDLE)
            ads_seen_q <= 1'b0;
        else if (!ads_n_q)
            ads_seen_q <= 1'b1;
        else if (ads_seen_q)
            ads_seen_q <= 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_q <= host_port_pkg::ST_IDLE;
            is_write_q <= 1'b0;
            addr_q <= '0;
            setup_cnt_q <= '0;
        end
        else
        begin
            unique case (state_q)
                host_port_pkg::ST_IDLE:
                begin
                    if (ads_seen_q && ads_n_q && !hcs_n_q)
                    begin
                        state_q <= host_port_pkg::ST_WAIT;
                        is_write_q <= !write_n_i;
                        addr_q <= addr_i;
                        setup_cnt_q <= '0;
                    end
                end
                host_port_pkg::ST_WAIT:
                begin
                    if (is_write_q && setup_cnt_q < host_port_pkg::CNT_W'(host_port_pkg::WR_DATA_SETUP_CLK))
                        setup_cnt_q <= setup_cnt_q + 1'b1;
                    else if (!is_write_q && setup_cnt_q < host_port_pkg::CNT_W'(host_port_pkg::RD_DATA_SETUP_CLK))
                        setup_cnt_q <= setup_cnt_q + 1'b1;
                    else
                        state_q <= host_port_pkg::ST_DONE;
                end
                host_port_pkg::ST_DONE:
                begin
                    if (!rdy_n_q)
                        state_q <= host_port_pkg::ST_IDLE;
                end
            endcase
        end
    end

    assign cycle_done = (state_q == host_port_pkg::ST_DONE) && !rdy_n_q;
    assign status_read_done = cycle_done && !is_write_q &&
        (addr_q == host_port_pkg::DMA_STATUS_ADDR || addr_q == host_port_pkg::SCSI_STATUS_FIRST_ADDR);

    assign ready_out_n_o = !(state_q == host_port_pkg::ST_DONE);

    // ======================================================================
    // Register data path
    logic [7:0] test8_q;
    logic [host_port_pkg::DATA_W-1:0] rdata_q;

    // Write sampled only once full setup window has elapsed
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            test8_q <= host_port_pkg::CHIP_TEST_EIGHTH_RST;
        else if (state_q == host_port_pkg::ST_WAIT && is_write_q &&
                 setup_cnt_q == host_port_pkg::CNT_W'(host_port_pkg::WR_DATA_SETUP_CLK) &&
                 addr_q == host_port_pkg::CHIP_TEST_EIGHTH_ADDR)
            test8_q <= wdata_i[7:0];
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rdata_q <= '0;
        else if (state_q == host_port_pkg::ST_IDLE)
            rdata_q <= '0;
        else if (state_q == host_port_pkg::ST_WAIT && setup_cnt_q == '0)
        begin
            unique case (addr_q)
                host_port_pkg::DMA_STATUS_ADDR: rdata_q <= {24'h000000, dma_status_i};
                host_port_pkg::SCSI_STATUS_FIRST_ADDR: rdata_q <= {24'h000000, scsi_status_first_i};
                host_port_pkg::CHIP_TEST_EIGHTH_ADDR: rdata_q <= {24'h000000, test8_q};
                default: rdata_q <= '0;
            endcase
        end
    end

    assign rdata_o = rdata_q;
    // Bus driven low-active enable only during read cycles
    assign rdata_oe_n_o = !(state_q != host_port_pkg::ST_IDLE && !is_write_q);
    assign chip_test_eighth_o = test8_q;
    assign scsi_clk_en_o = test8_q[host_port_pkg::SCLK_EN_BIT];

    // ======================================================================
    // Interrupt output
    logic pend_q;
    logic irq_q;
    logic [host_port_pkg::CNT_W-1:0] irq_cnt_q;

    // Pending flag: a new event wins over a clear in the same cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            pend_q <= 1'b0;
        else if (irq_event_i)
            pend_q <= 1'b1;
        else if (irq_q && status_read_done)
            pend_q <= 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_q <= 1'b0;
            irq_cnt_q <= host_port_pkg::CNT_W'(host_port_pkg::IRQ_MIN_GAP_CLK);
        end
        else if (irq_q)
        begin
            if (irq_cnt_q != '1)
                irq_cnt_q <= irq_cnt_q + 1'b1;
            if (status_read_done && irq_cnt_q >= host_port_pkg::CNT_W'(host_port_pkg::IRQ_MIN_LOW_CLK - 1))
            begin
                irq_q <= 1'b0;
                irq_cnt_q <= '0;
            end
        end
        else
        begin
            if (irq_cnt_q != '1)
                irq_cnt_q <= irq_cnt_q + 1'b1;
            if (pend_q && irq_cnt_q >= host_port_pkg::CNT_W'(host_port_pkg::IRQ_MIN_GAP_CLK))
            begin
                irq_q <= 1'b1;
                irq_cnt_q <= '0;
            end
        end
    end

    assign irq_n_o = !irq_q;
endmodule : host_slave_port
`default_nettype wire

// ### host_port_pkg.sv
// Constants for the host slave port and interrupt output
`default_nettype none
package host_port_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // Register addresses seen by the host (byte index)
    localparam logic [ADDR_W-1:0] DMA_STATUS_ADDR = 8'h0C;
    localparam logic [ADDR_W-1:0] SCSI_STATUS_FIRST_ADDR = 8'h0D;
    localparam logic [ADDR_W-1:0] CHIP_TEST_EIGHTH_ADDR = 8'h22;
    localparam int SCLK_EN_BIT = 7;
    localparam logic [7:0] CHIP_TEST_EIGHTH_RST = 8'h00;
    // Interrupt timing in clocks
    localparam int IRQ_MIN_LOW_CLK = 3;
    localparam int IRQ_MIN_GAP_CLK = 6;
    // Data timing in clocks before the sampling edge
    localparam int WR_DATA_SETUP_CLK = 6;
    localparam int RD_DATA_SETUP_CLK = 2;
    localparam int CNT_W = 4;
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DONE} slave_state_t;
endpackage : host_port_pkg
`default_nettype wire

// ### host_slave_port_sva.sv
// Assertion checker for the host slave port
`default_nettype none
module host_slave_port_sva (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic host_chip_select_n_i,
    input wire logic write_n_i,
    input wire logic [host_port_pkg::ADDR_W-1:0] addr_i,
    input wire logic [host_port_pkg::DATA_W-1:0] wdata_i,
    input wire logic ready_in_n_i,
    input wire logic [host_port_pkg::DATA_W-1:0] rdata_o,
    input wire logic ready_out_n_o,
    input wire logic irq_n_o,
    input wire logic [7:0] chip_test_eighth_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ==========
    // Completion of a status read
    sequence s_stat_rd;
        $rose(ready_out_n_o) && write_n_i &&
            (addr_i == host_port_pkg::DMA_STATUS_ADDR || addr_i == host_port_pkg::SCSI_STATUS_FIRST_ADDR);
    endsequence
    property p_sel; !ready_out_n_o |-> !host_chip_select_n_i; endproperty
    a_sel: assert property (p_sel) else $error("ready without select");
    property p_hold; !ready_out_n_o && ready_in_n_i |=> !ready_out_n_o; endproperty
    a_hold: assert property (p_hold) else $error("ready dropped early");
    property p_done; $fell(ready_in_n_i) && !ready_out_n_o |-> ##[1:5] ready_out_n_o; endproperty
    a_done: assert property (p_done) else $error("cycle not ended");
    property p_low; $fell(irq_n_o) |-> !irq_n_o [*3]; endproperty
    a_low: assert property (p_low) else $error("irq low too short");
    property p_gap; $rose(irq_n_o) |-> irq_n_o [*6]; endproperty
    a_gap: assert property (p_gap) else $error("irq gap too short");
    property p_rel; $rose(irq_n_o) |-> s_stat_rd; endproperty
    a_rel: assert property (p_rel) else $error("irq released without status read");
    property p_rd; $fell(ready_out_n_o) && write_n_i |-> rdata_o == $past(rdata_o, 2); endproperty
    a_rd: assert property (p_rd) else $error("read data late");
    property p_wr;
        $changed(chip_test_eighth_o) |-> !write_n_i && addr_i == host_port_pkg::CHIP_TEST_EIGHTH_ADDR &&
            chip_test_eighth_o == wdata_i[7:0];
    endproperty
    a_wr: assert property (p_wr) else $error("bad register write");
endmodule : host_slave_port_sva
bind host_slave_port host_slave_port_sva u_host_slave_port_sva (.clk_i, .rst_i, .host_chip_select_n_i,
    .write_n_i, .addr_i, .wdata_i, .ready_in_n_i, .rdata_o, .ready_out_n_o, .irq_n_o, .chip_test_eighth_o);
`default_nettype wire

// ### host_bus_model.sv
// Host processor model driving slave register cycles
`default_nettype none
module host_bus_model (
    input wire logic clk_i,
    input wire logic ready_out_n_i,
    input wire logic [31:0] rdata_i,
    output logic address_strobe_n_o,
    output logic host_chip_select_n_o,
    output logic next_address_n_o,
    output logic write_n_o,
    output logic [7:0] addr_o,
    output logic [31:0] wdata_o,
    output logic ready_in_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========
    // Idle bus at time zero
    initial {address_strobe_n_o, host_chip_select_n_o, write_n_o, ready_in_n_o, addr_o, wdata_o} = '1;
    initial next_address_n_o = 1'b1;
    always @(negedge clk_i) next_address_n_o <= ~next_address_n_o;
    // data held whole cycle, ready returned
    task automatic access(input logic w, input logic c, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic ok);
        int n;
        @(negedge clk_i);
        {write_n_o, host_chip_select_n_o, addr_o, wdata_o, address_strobe_n_o} = {w, c, a, d, 1'b0};
        // Pin filter wants two agreeing samples, so a one-clock strobe would vanish
        @(negedge clk_i);
        @(negedge clk_i);
        address_strobe_n_o = 1'b1;
        n = 0;
        while (ready_out_n_i !== 1'b0 && n < 20) begin @(posedge clk_i); n++; end
        q = rdata_i;
        ok = (n < 20);
        if (ok) begin @(negedge clk_i); ready_in_n_o = 1'b0; n = 0;
            while (ready_out_n_i !== 1'b1 && n < 20) begin @(posedge clk_i); n++; end
            ok = (n < 20);
        end
        // Released lines show the inverse so stale values never pass
        @(negedge clk_i);
        {ready_in_n_o, host_chip_select_n_o, write_n_o, addr_o, wdata_o} = {2'b11, ~w, ~a, ~d};
    endtask : access
endmodule : host_bus_model
`default_nettype wire

// ### host_slave_port_tb_top.sv
// Self-checking testbench for the host slave port
`default_nettype none
module host_slave_port_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic as_n, cs_n, na_n, wr_n, rin_n, rout_n, oe_n, irq_n, sen, ok;
    logic ev = 1'b0;
    logic [7:0] adr, ct8;
    logic [7:0] dsts = 8'hA5;
    logic [7:0] ssts = 8'h5A;
    logic [31:0] wd, rd, q;
    int err_count = 0;
    int checked = 0;
    always #25 clk_i = ~clk_i;
    host_slave_port u_host_slave_port (.clk_i(clk_i), .rst_i(rst_i), .address_strobe_n_i(as_n),
        .host_chip_select_n_i(cs_n), .next_address_n_i(na_n), .write_n_i(wr_n), .addr_i(adr), .wdata_i(wd),
        .ready_in_n_i(rin_n), .dma_status_i(dsts), .scsi_status_first_i(ssts), .irq_event_i(ev), .rdata_o(rd),
        .rdata_oe_n_o(oe_n), .ready_out_n_o(rout_n), .irq_n_o(irq_n), .scsi_clk_en_o(sen),
        .chip_test_eighth_o(ct8));
    host_bus_model u_host_bus_model (.clk_i(clk_i), .ready_out_n_i(rout_n), .rdata_i(rd),
        .address_strobe_n_o(as_n), .host_chip_select_n_o(cs_n), .next_address_n_o(na_n), .write_n_o(wr_n),
        .addr_o(adr), .wdata_o(wd), .ready_in_n_o(rin_n));
    // ==========
    // Compare and report
    task chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin err_count++; $display("[ERR] %0t seen %h expected %h", $time, s, e); end
    endtask : chk
    task summarize;
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize
    // Reset values, then the clock enable bit written both ways
    task t_regs;
        chk({rout_n, irq_n, sen, oe_n}, 4'hD);
        chk(ct8, 8'h00);
        u_host_bus_model.access(1'b0, 1'b0, 8'h22, 32'hFFFF_FF80, q, ok);
        chk({ok, sen, ct8}, 10'h380);
        u_host_bus_model.access(1'b0, 1'b0, 8'h22, 32'h0000_007F, q, ok);
        chk({ok, sen, ct8}, 10'h27F);
        $display("t_regs done");
    endtask : t_regs
    // Reads of both status places, an unmapped place, and a deselected strobe
    task t_read;
        u_host_bus_model.access(1'b1, 1'b0, 8'h0D, 32'h0, q, ok);
        chk(q, 32'h5A);
        u_host_bus_model.access(1'b1, 1'b0, 8'h0C, 32'h0, q, ok);
        chk(q, 32'hA5);
        u_host_bus_model.access(1'b1, 1'b0, 8'h40, 32'h0, q, ok);
        chk(q, 32'h0);
        chk({31'h0, ok}, 32'h1);
        u_host_bus_model.access(1'b1, 1'b1, 8'h0C, 32'h0, q, ok);
        chk(ok, 1'b0);
        $display("t_read done");
    endtask : t_read
    // Interrupt raised, kept by other reads, released and stacked
    task t_irq;
        @(negedge clk_i) ev = 1'b1;
        @(negedge clk_i) ev = 1'b0;
        repeat (12) @(negedge clk_i);
        chk(irq_n, 1'b0);
        u_host_bus_model.access(1'b1, 1'b0, 8'h40, 32'h0, q, ok);
        chk(irq_n, 1'b0);
        u_host_bus_model.access(1'b1, 1'b0, 8'h0C, 32'h0, q, ok);
        chk(irq_n, 1'b1);
        ev = 1'b1;
        @(negedge clk_i) ev = 1'b0;
        // Released only a few clocks ago, so still inside the quiet gap
        repeat (2) @(negedge clk_i);
        chk(irq_n, 1'b1);
        repeat (10) @(negedge clk_i);
        chk(irq_n, 1'b0);
        u_host_bus_model.access(1'b1, 1'b0, 8'h0D, 32'h0, q, ok);
        chk(irq_n, 1'b1);
        $display("t_irq done");
    endtask : t_irq
    // Main sequence
    initial
    begin
        repeat (5) @(posedge clk_i);
        @(negedge clk_i) rst_i = 1'b0;
        t_regs();
        t_read();
        t_irq();
        summarize();
    end
    // Watchdog sized well beyond the expected run
    initial
    begin
        #100000;
        err_count++;
        summarize();
    end
endmodule : host_slave_port_tb_top
`default_nettype wire
